// [wit_pkg.sv]
// constants and register map of the watchdog and interval timer
package wit_pkg;

    // ========================================================
    // register bus shape
    // ========================================================
    localparam int WIT_AW = 4;                  // address width
    localparam int WIT_WW = 16;                 // write data width
    localparam int WIT_DW = 8;                  // register width

    // ========================================================
    // register offsets
    // ========================================================
    localparam logic [3:0] WIT_OFS_CNT  = 4'h0; // watchdog_up_counter
    localparam logic [3:0] WIT_OFS_CTL  = 4'h1; // timer_control_status
    localparam logic [3:0] WIT_OFS_RST  = 4'h2; // reset_control_register
    localparam logic [3:0] WIT_OFS_IST  = 4'h3; // event status, read only
    localparam logic [3:0] WIT_OFS_IEN  = 4'h4; // event enable
    localparam logic [3:0] WIT_OFS_ICLR = 4'h5; // event clear, write only

    // ========================================================
    // protected write keys, upper byte of a 16-bit write
    // ========================================================
    localparam logic [7:0] WIT_KEY_CNT = 8'h5a; // key for the counter
    localparam logic [7:0] WIT_KEY_CTL = 8'ha5; // key for control/status
    localparam logic [7:0] WIT_KEY_RST = 8'h5a; // key for reset control

    // ========================================================
    // field positions
    // ========================================================
    localparam int WIT_CTL_OVF  = 7;            // interval_overflow_flag
    localparam int WIT_CTL_MODE = 6;            // mode_select_bit, 1 = wd
    localparam int WIT_CTL_TME  = 5;            // timer_enable_bit
    localparam int WIT_RST_WOVF = 7;            // watchdog overflow flag
    localparam int WIT_RST_RSTE = 6;            // internal reset enable
    localparam int WIT_RST_RSTS = 5;            // 0 power-on, 1 manual
    localparam int WIT_EV_ITV   = 0;            // interval overflow event
    localparam int WIT_EV_WD    = 1;            // watchdog overflow event

    // ========================================================
    // reset values and counter limit
    // ========================================================
    localparam logic [7:0] WIT_CNT_RST   = 8'h00; // counter after reset
    localparam logic [7:0] WIT_CNT_MAX   = 8'hff; // value that wraps
    localparam logic [7:0] WIT_CTL_RSV   = 8'h18; // bits 4,3 read as one
    localparam logic [2:0] WIT_CKS_RST   = 3'h0;  // clock select at reset
    localparam logic [1:0] WIT_EV_RST    = 2'h0;  // status/enable reset

    // ========================================================
    // prescaler taps: phi/2,64,128,256,512,1024,4096,8192
    // ========================================================
    localparam int WIT_PW = 13;
    localparam logic [12:0] WIT_DIV_MASK [8] = '{
        13'h0001, 13'h003f, 13'h007f, 13'h00ff,
        13'h01ff, 13'h03ff, 13'h0fff, 13'h1fff};

    // ========================================================
    // timing
    // ========================================================
    localparam int WIT_CLK_NS       = 10;   // core_clk period
    localparam int WIT_PULSE_NS     = 640;  // overflow pin low time
    localparam int WIT_PULSE_CYC_I  =
        (WIT_PULSE_NS + WIT_CLK_NS - 1) / WIT_CLK_NS;
    localparam logic [6:0] WIT_PULSE_CYC = 7'(WIT_PULSE_CYC_I);

endpackage

// [wit_watchdog.sv]
// watchdog and interval timer with protected register writes
//
// What this block does
// - 8-bit timer resets chip on missed rewrite
// - watchdog or interval mode decides overflow response
// - watchdog overflow drives overflow pin
// - optional internal reset, power-on or manual
// - interval overflow raises interval interrupt
// - interval overflow wakes from software standby
// - three-bit select picks one of eight clocks
// - count selected clock only while enabled
// - overflow is wrap from ff to 00
// - counter is zero after reset
// - only keyed writes change protected registers
// - overflow flag set in interval mode only
// - flag clears by zero write after read
// - enable cleared in interval mode clears flag
// - disabled timer holds counter at zero
// - mode bit: 0 interval, 1 watchdog
// - select codes map to fixed divider ratios
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module wit_watchdog
    import wit_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [WIT_AW-1:0]    reg_addr,
    input  wire logic [WIT_WW-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [WIT_DW-1:0]    reg_rdata,
    output logic                      overflow_out_pin_n,
    output logic                      interval_interrupt,
    output logic                      standby_wake,
    output logic                      por_reset_req,
    output logic                      manual_reset_req,
    output logic                      irq
);
    import wit_pkg::*;

    // ========================================================
    // state
    // ========================================================
    logic [WIT_PW-1:0] presc_r,  presc_nxt;   // prescale divider, zero while disabled
    logic [7:0]        cnt_r,    cnt_nxt;     // watchdog_up_counter
    logic              ovf_r,    ovf_nxt;     // interval_overflow_flag
    logic              ovf_arm_r, ovf_arm_nxt; // flag read as one
    logic              mode_r,   mode_nxt;    // mode_select_bit
    logic              tme_r,    tme_nxt;     // timer_enable_bit
    logic [2:0]        cks_r,    cks_nxt;     // clock_select_field
    logic              wovf_r,   wovf_nxt;    // watchdog overflow flag
    logic              wovf_arm_r, wovf_arm_nxt; // wovf read as one
    logic              rste_r,   rste_nxt;    // internal reset enable
    logic              rsts_r,   rsts_nxt;    // reset kind select
    logic [6:0]        pls_r,    pls_nxt;     // pin low cycles left
    logic              pin_n_r,  pin_n_nxt;   // registered pin level
    logic              por_r,    por_nxt;     // power-on request
    logic              man_r,    man_nxt;     // manual request
    logic              wake_r,   wake_nxt;    // standby wake pulse
    logic [1:0]        ist_r,    ist_nxt;     // sticky event status
    logic [1:0]        ien_r,    ien_nxt;     // event enable
    logic [7:0]        rdata_r,  rdata_nxt;   // read data register

    // ========================================================
    // decode
    // ========================================================
    logic       key_cnt;    // keyed write to the counter
    logic       key_ctl;    // keyed write to control/status
    logic       key_rst;    // keyed write to reset control
    logic       tick;       // selected prescaled clock pulse
    logic       ovf_evt;    // counter wraps this cycle
    logic       wd_evt;     // overflow in watchdog mode
    logic       it_evt;     // overflow in interval mode
    logic [7:0] wlo;        // data byte of a write
    logic [7:0] ctl_view;   // control/status as read

    assign wlo = reg_wdata[7:0];

    // keys sit in the upper byte; a plain write never matches
    // counter and reset control share a key; the address splits them
    assign key_cnt = reg_wr && reg_addr == WIT_OFS_CNT &&
                     reg_wdata[15:8] == WIT_KEY_CNT;
    assign key_ctl = reg_wr && reg_addr == WIT_OFS_CTL &&
                     reg_wdata[15:8] == WIT_KEY_CTL;
    assign key_rst = reg_wr && reg_addr == WIT_OFS_RST &&
                     reg_wdata[15:8] == WIT_KEY_RST;

    // all-ones on the low bits of the divider marks a tap edge
    assign tick = (presc_r & WIT_DIV_MASK[cks_r]) ==
                  WIT_DIV_MASK[cks_r];

    // a keyed counter write in the same cycle wins over the wrap
    assign ovf_evt = tme_r && tick && cnt_r == WIT_CNT_MAX &&
                     !key_cnt;
    assign wd_evt  = ovf_evt && mode_r;
    assign it_evt  = ovf_evt && !mode_r;

    assign ctl_view = {ovf_r, mode_r, tme_r, 2'b00, cks_r} | WIT_CTL_RSV;

    // ========================================================
    // timer core: next values
    // ========================================================
    always_comb begin
        // control/status fields
        mode_nxt = mode_r;
        tme_nxt  = tme_r;
        cks_nxt  = cks_r;
        if (key_ctl) begin
            mode_nxt = wlo[WIT_CTL_MODE];
            tme_nxt  = wlo[WIT_CTL_TME];
            cks_nxt  = wlo[2:0];
        end
        // prescaler only runs while enabled and already steps in the enabling cycle,
        // so a fresh start's first period is one cycle short
        presc_nxt = tme_nxt ? presc_r + 13'h0001 : '0;
        // counter
        cnt_nxt = cnt_r;
        if (tme_r && tick) begin
            cnt_nxt = cnt_r + 8'h01;
        end
        if (key_cnt) begin
            cnt_nxt = wlo;
        end
        if (!tme_nxt) begin
            cnt_nxt = WIT_CNT_RST;
        end
        // interval flag: clears first, then the set wins
        // the arm is taken only by a read strobe that saw a one, so a
        // read of zero never licenses a clear
        ovf_nxt     = ovf_r;
        ovf_arm_nxt = ovf_arm_r;
        if (reg_rd && reg_addr == WIT_OFS_CTL && ovf_r) begin
            ovf_arm_nxt = 1'b1;
        end
        if (key_ctl) begin
            if (!wlo[WIT_CTL_OVF] && ovf_arm_r) begin
                ovf_nxt = 1'b0;
            end
            if (!wlo[WIT_CTL_TME] && !mode_r) begin
                ovf_nxt = 1'b0;
            end
            ovf_arm_nxt = 1'b0;
        end
        if (it_evt) begin
            ovf_nxt = 1'b1;
        end
        // reset control register
        rste_nxt     = rste_r;
        rsts_nxt     = rsts_r;
        wovf_nxt     = wovf_r;
        wovf_arm_nxt = wovf_arm_r;
        if (reg_rd && reg_addr == WIT_OFS_RST && wovf_r) begin
            wovf_arm_nxt = 1'b1;
        end
        if (key_rst) begin
            rste_nxt = wlo[WIT_RST_RSTE];
            rsts_nxt = wlo[WIT_RST_RSTS];
            if (!wlo[WIT_RST_WOVF] && wovf_arm_r) begin
                wovf_nxt = 1'b0;
            end
            wovf_arm_nxt = 1'b0;
        end
        if (wd_evt) begin
            wovf_nxt = 1'b1;
        end
        // overflow pin pulse, restarted by every watchdog overflow
        pls_nxt = pls_r;
        if (wd_evt) begin
            pls_nxt = WIT_PULSE_CYC;
        end else if (pls_r != 7'h00) begin
            pls_nxt = pls_r - 7'h01;
        end
        pin_n_nxt = (pls_nxt == 7'h00);
        // one-cycle requests toward reset logic and standby control
        por_nxt  = wd_evt && rste_r && !rsts_r;
        man_nxt  = wd_evt && rste_r && rsts_r;
        wake_nxt = it_evt;
    end

    // ========================================================
    // timer core: registers
    // ========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            presc_r    <= '0;
            cnt_r      <= WIT_CNT_RST;
            ovf_r      <= 1'b0;
            ovf_arm_r  <= 1'b0;
            mode_r     <= 1'b0;
            tme_r      <= 1'b0;
            cks_r      <= WIT_CKS_RST;
            wovf_r     <= 1'b0;
            wovf_arm_r <= 1'b0;
            rste_r     <= 1'b0;
            rsts_r     <= 1'b0;
            pls_r      <= 7'h00;
            pin_n_r    <= 1'b1;
            por_r      <= 1'b0;
            man_r      <= 1'b0;
            wake_r     <= 1'b0;
        end else begin
            presc_r    <= presc_nxt;
            cnt_r      <= cnt_nxt;
            ovf_r      <= ovf_nxt;
            ovf_arm_r  <= ovf_arm_nxt;
            mode_r     <= mode_nxt;
            tme_r      <= tme_nxt;
            cks_r      <= cks_nxt;
            wovf_r     <= wovf_nxt;
            wovf_arm_r <= wovf_arm_nxt;
            rste_r     <= rste_nxt;
            rsts_r     <= rsts_nxt;
            pls_r      <= pls_nxt;
            pin_n_r    <= pin_n_nxt;
            por_r      <= por_nxt;
            man_r      <= man_nxt;
            wake_r     <= wake_nxt;
        end
    end

    // ========================================================
    // event status, enable and read data: next values
    // ========================================================
    always_comb begin
        ist_nxt = ist_r;
        ien_nxt = ien_r;
        if (reg_wr && reg_addr == WIT_OFS_IEN) begin
            ien_nxt = wlo[1:0];
        end
        // clear first so that an event in the same cycle survives
        if (reg_wr && reg_addr == WIT_OFS_ICLR) begin
            ist_nxt = ist_r & ~wlo[1:0];
        end
        if (it_evt) begin
            ist_nxt[WIT_EV_ITV] = 1'b1;
        end
        if (wd_evt) begin
            ist_nxt[WIT_EV_WD] = 1'b1;
        end
        // read mux, data valid only in the cycle after the strobe
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                WIT_OFS_CNT: rdata_nxt = cnt_r;
                WIT_OFS_CTL: rdata_nxt = ctl_view;
                WIT_OFS_RST: rdata_nxt = {wovf_r, rste_r, rsts_r, 5'h00};
                WIT_OFS_IST: rdata_nxt = {6'h00, ist_r};
                WIT_OFS_IEN: rdata_nxt = {6'h00, ien_r};
                default:     rdata_nxt = 8'h00;    // unmapped reads zero
            endcase
        end
    end

    // ========================================================
    // event status, enable and read data: registers
    // ========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ist_r   <= WIT_EV_RST;
            ien_r   <= WIT_EV_RST;
            rdata_r <= 8'h00;
        end else begin
            ist_r   <= ist_nxt;
            ien_r   <= ien_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ========================================================
    // outputs
    // ========================================================
    assign reg_rdata          = rdata_r;
    assign overflow_out_pin_n = pin_n_r;
    // the interrupt mirrors the flag and stays up until it is cleared
    assign interval_interrupt = ovf_r;
    assign standby_wake       = wake_r;
    assign por_reset_req      = por_r;
    assign manual_reset_req   = man_r;
    // level output, high while any enabled event is pending
    assign irq                = |(ist_r & ien_r);

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // the bound holds unless a keyed reload near ff forces a second
    // wrap inside one pulse, which stretches the low time on purpose
    logic [7:0] low_len_r;  // consecutive low cycles on the pin
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            low_len_r <= 8'h00;
        end else if (!pin_n_r) begin
            low_len_r <= low_len_r + 8'h01;
        end else begin
            low_len_r <= 8'h00;
        end
    end

    cnt_hold_a: assert property (!tme_r |-> cnt_r == 8'h00)
        else $error("counter not zero while disabled");

    cnt_step_a: assert property (
        tme_r && tick && !key_cnt && !key_ctl |=>
        cnt_r == $past(cnt_r) + 8'h01)
        else $error("counter missed a tick");

    pin_fall_a: assert property (wd_evt |=> !pin_n_r)
        else $error("overflow pin not driven low");

    pin_len_a: assert property (
        low_len_r <= 8'(WIT_PULSE_CYC_I))
        else $error("overflow pin low too long");

    itv_flag_a: assert property (
        it_evt |=> ovf_r && interval_interrupt && pin_n_r)
        else $error("interval overflow response wrong");

    flag_mode_a: assert property (
        $rose(ovf_r) |-> $past(!mode_r))
        else $error("flag set in watchdog mode");

    plain_write_a: assert property (
        reg_wr && reg_addr == WIT_OFS_CTL && !key_ctl |=>
        mode_r == $past(mode_r) && cks_r == $past(cks_r))
        else $error("plain write changed control");

    flag_clear_a: assert property (
        ovf_r && key_ctl && !ovf_arm_r && wlo[WIT_CTL_TME] |=> ovf_r)
        else $error("flag cleared without prior read");

    reset_req_a: assert property (
        wd_evt && rste_r |=> (por_reset_req != manual_reset_req) &&
        manual_reset_req == $past(rsts_r))
        else $error("wrong internal reset request");

    wake_a: assert property (it_evt |=> standby_wake ##1 !standby_wake)
        else $error("wake pulse wrong");

    tick_gap_a: assert property (tick && tme_r |=> !tick)
        else $error("tick on consecutive cycles");

    // a disable write in interval mode drops the flag unless a wrap
    // lands in the same cycle, in which case the set wins
    tme_clear_a: assert property (
        key_ctl && !wlo[WIT_CTL_TME] && !mode_r && !it_evt |=> !ovf_r)
        else $error("flag kept after interval disable");

    flag_zero_a: assert property (
        key_ctl && ovf_arm_r && !wlo[WIT_CTL_OVF] && !it_evt |=> !ovf_r)
        else $error("flag kept after read and zero write");

    cnt_wrap_a: assert property (ovf_evt |=> cnt_r == 8'h00)
        else $error("counter did not wrap to zero");

    wd_flag_a: assert property (wd_evt |=> wovf_r)
        else $error("watchdog flag not set");

    // the interval flag must stay quiet across watchdog overflows
    wd_quiet_a: assert property (
        wd_evt && !ovf_r |=> !ovf_r)
        else $error("interval flag set by watchdog overflow");

    wake_mode_a: assert property (
        standby_wake |-> $past(!mode_r))
        else $error("wake pulse from watchdog mode");

    wd_cov: cover property (wd_evt ##1 !pin_n_r);
    itv_cov: cover property (it_evt ##1 irq);
    clr_cov: cover property (ovf_arm_r && key_ctl && !wlo[WIT_CTL_OVF]);
    rst_cov: cover property (por_reset_req);
    tme_cov: cover property (key_ctl && !wlo[WIT_CTL_TME] && ovf_r);

endmodule

// [wit_host_model.sv]
// reset logic and standby side model that watches the timer outputs
`timescale 1ns/10ps
module wit_host_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       overflow_out_pin_n,
    input  wire logic       standby_wake,
    input  wire logic       por_reset_req,
    input  wire logic       manual_reset_req,
    output logic      [7:0] por_cnt,     // power-on reset requests seen
    output logic      [7:0] man_cnt,     // manual reset requests seen
    output logic      [7:0] wake_cnt,    // standby wake pulses seen
    output logic      [7:0] low_run,     // current low run of the pin
    output logic      [7:0] last_low,    // length of the last low run
    output logic      [7:0] low_tot      // all low cycles, saturating
);
    // ========================================================
    // event counting
    // ========================================================
    // reset logic only counts requests; the chip reset itself is not
    // looped back, so the timer keeps running after a request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            por_cnt  <= 8'h00;
            man_cnt  <= 8'h00;
            wake_cnt <= 8'h00;
            low_run  <= 8'h00;
            last_low <= 8'h00;
            low_tot  <= 8'h00;
        end else begin
            por_cnt  <= por_cnt + 8'(por_reset_req);
            man_cnt  <= man_cnt + 8'(manual_reset_req);
            wake_cnt <= wake_cnt + 8'(standby_wake);
            if (overflow_out_pin_n === 1'b0) begin
                low_run <= low_run + 8'h01;
                if (low_tot != 8'hff) begin
                    low_tot <= low_tot + 8'h01;
                end
            end else if (low_run != 8'h00) begin
                last_low <= low_run;
                low_run  <= 8'h00;
            end
        end
    end
endmodule

// [tb_watchdog_interval_timer.sv]
// self-checking bench for the watchdog and interval timer
`timescale 1ns/10ps
// compares settle 1 ns past the edge, after the registers have moved
`define CHK(got, exp) begin #1; samples_checked++; \
    if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_watchdog_interval_timer;
    import wit_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst_n    = 1'b0;
    logic [WIT_AW-1:0] reg_addr = '0;
    logic [WIT_WW-1:0] reg_wdata = '0;
    logic              reg_wr   = 1'b0;
    logic              reg_rd   = 1'b0;
    logic [WIT_DW-1:0] reg_rdata;
    logic              ovf_pin_n, itv_int, wake, por_req, man_req, irq;
    logic [7:0]        por_cnt, man_cnt, wake_cnt, low_run, last_low;
    logic [7:0]        low_tot;
    int                mismatches = 0;
    int                samples_checked = 0;
    int                dv;
    always #5 core_clk = ~core_clk;    // 100 MHz
    wit_watchdog u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .overflow_out_pin_n(ovf_pin_n), .interval_interrupt(itv_int),
        .standby_wake(wake), .por_reset_req(por_req),
        .manual_reset_req(man_req), .irq(irq));
    wit_host_model u_host (.core_clk(core_clk), .rst_n(rst_n),
        .overflow_out_pin_n(ovf_pin_n), .standby_wake(wake),
        .por_reset_req(por_req), .manual_reset_req(man_req),
        .por_cnt(por_cnt), .man_cnt(man_cnt), .wake_cnt(wake_cnt),
        .low_run(low_run), .last_low(last_low), .low_tot(low_tot));
    // ========================================================
    // bus tasks
    // ========================================================
    // one-cycle write strobe; the data byte rides under the key byte
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe edge
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        `CHK(reg_rdata, exp)
    endtask
    // bounded wait: sel 0 interval interrupt, 1 overflow pin
    task automatic wait_sig(input int sel, input logic lvl);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge core_clk);
            #1;
            if ((sel == 0 ? itv_int : ovf_pin_n) === lvl) begin
                return;
            end
        end
        mismatches++;
        $display("[FAIL] t=%0t wait sel=%h lvl=%h", $time, sel, lvl);
    endtask
    task automatic report_and_stop();
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ========================================================
    // tests
    // ========================================================
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_rd(WIT_OFS_CNT, 8'h00);
        chk_rd(WIT_OFS_CTL, 8'h18);
        chk_rd(WIT_OFS_RST, 8'h00);
        chk_rd(WIT_OFS_IST, 8'h00);
        chk_rd(4'h9, 8'h00);
        // plain writes must bounce off control/status and the counter
        wr(WIT_OFS_CTL, 16'h0060);
        wr(WIT_OFS_CNT, 16'h0033);
        chk_rd(WIT_OFS_CTL, 8'h18);
        chk_rd(WIT_OFS_CNT, 8'h00);
        wr(WIT_OFS_CNT, {WIT_KEY_CNT, 8'h40});
        chk_rd(WIT_OFS_CNT, 8'h00);
        // every select code: two ticks land, the third not yet
        for (int k = 0; k < 8; k++) begin
            dv = int'(WIT_DIV_MASK[k]) + 1;
            wr(WIT_OFS_CTL, {WIT_KEY_CTL, 5'h00, 3'(k)});
            wr(WIT_OFS_CTL, {WIT_KEY_CTL, 5'h04, 3'(k)});
            repeat (2 * dv + dv / 2 - 2) @(posedge core_clk);
            chk_rd(WIT_OFS_CNT, 8'h02);
        end
        // interval overflow from a preloaded count
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'h20});
        wr(WIT_OFS_CNT, {WIT_KEY_CNT, 8'hf0});
        wait_sig(0, 1'b1);
        `CHK(itv_int, 1'b1)
        chk_rd(WIT_OFS_CTL, 8'hb8);
        `CHK(wake_cnt, 8'h01)
        `CHK(low_tot, 8'h00)
        chk_rd(WIT_OFS_IST, 8'h01);
        wr(WIT_OFS_IEN, 16'h0001);
        `CHK(irq, 1'b1)
        // writing one keeps the flag; a zero without a read keeps it too
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'ha0});
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'h20});
        chk_rd(WIT_OFS_CTL, 8'hb8);
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'h20});
        chk_rd(WIT_OFS_CTL, 8'h38);
        `CHK(itv_int, 1'b0)
        // disabling in interval mode drops the flag and the count
        wr(WIT_OFS_CNT, {WIT_KEY_CNT, 8'hf0});
        wait_sig(0, 1'b1);
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'h00});
        chk_rd(WIT_OFS_CTL, 8'h18);
        chk_rd(WIT_OFS_CNT, 8'h00);
        wr(WIT_OFS_ICLR, 16'h0001);
        chk_rd(WIT_OFS_IST, 8'h00);
        `CHK(irq, 1'b0)
        // watchdog overflow with power-on reset request
        wr(WIT_OFS_RST, {WIT_KEY_RST, 8'h40});
        wr(WIT_OFS_IEN, 16'h0002);
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'h60});
        wr(WIT_OFS_CNT, {WIT_KEY_CNT, 8'hf0});
        wait_sig(1, 1'b0);
        repeat (2) @(posedge core_clk);
        `CHK(por_cnt, 8'h01)
        `CHK(irq, 1'b1)
        wait_sig(1, 1'b1);
        // the host files the low run one edge after the pin rises
        @(posedge core_clk);
        `CHK(last_low, 8'(WIT_PULSE_CYC))
        `CHK(low_run, 8'h00)
        `CHK(itv_int, 1'b0)
        chk_rd(WIT_OFS_RST, 8'hc0);
        chk_rd(WIT_OFS_IST, 8'h02);
        // manual reset kind
        wr(WIT_OFS_RST, {WIT_KEY_RST, 8'h60});
        wr(WIT_OFS_CNT, {WIT_KEY_CNT, 8'hf0});
        wait_sig(1, 1'b0);
        repeat (2) @(posedge core_clk);
        `CHK(man_cnt, 8'h01)
        `CHK(por_cnt, 8'h01)
        `CHK(wake_cnt, 8'h02)
        wr(WIT_OFS_CTL, {WIT_KEY_CTL, 8'h40});
        report_and_stop();
    end
    // ========================================================
    // watchdog: tests take under 0.4 ms, limit at 0.8 ms
    // ========================================================
    initial begin
        #800000;
        mismatches++;
        report_and_stop();
    end
endmodule
